/* File: rtl/serial_rx_unit.sv */
// Async serial channel: receive with errors, parity, noise filter, baud generator
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module serial_rx_unit
  import serial_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            rx_done_irq,
  output logic            rx_error_irq,
  output logic            tx_done_irq
);
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_e;

  // Parity bit that a transmitter appends for the given data
  function automatic logic par_bit(input logic [7:0] d, input logic len8, input parity_e m);
    logic ones;
    ones = len8 ? ^d : ^d[6:0];
    case (m)
      PAR_EVEN: par_bit = ones;
      PAR_ODD:  par_bit = ~ones;
      default:  par_bit = 1'b0;
    endcase
  endfunction

  // ===========================================================
  // Registers
  logic [7:0] mode_q, clk_sel_q, baud_div_q, rx_buf_q, tx_data_q;
  logic [2:0] status_q;
  logic       tx_start_q;
  logic       unit_en, rx_en, tx_en, len8, merge;
  parity_e    par_mode;
  assign unit_en  = mode_q[MODE_UNIT_EN];
  assign rx_en    = mode_q[MODE_RX_EN] & unit_en;
  assign tx_en    = mode_q[MODE_TX_EN] & unit_en;
  assign len8     = mode_q[MODE_LEN8];
  assign merge    = mode_q[MODE_IRQ_MERGE];
  assign par_mode = parity_e'(mode_q[MODE_PAR_HI:MODE_PAR_LO]);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q     <= MODE_RESET;
      clk_sel_q  <= CLK_SELECT_RESET;
      baud_div_q <= BAUD_DIV_RESET;
      tx_data_q  <= 8'h00;
      tx_start_q <= 1'b0;
    end
    else
    begin
      tx_start_q <= wr && addr == ADDR_TX_DATA && tx_en;
      if (wr)
      begin
        if (addr == ADDR_MODE_CTRL)
          mode_q <= wdata;
        else if (addr == ADDR_CLK_SELECT)
          clk_sel_q <= wdata;
        else if (addr == ADDR_BAUD_DIV)
          baud_div_q <= (wdata < BAUD_DIV_MIN) ? BAUD_DIV_MIN : wdata;
        else if (addr == ADDR_TX_DATA)
          tx_data_q <= wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
    begin
      if (addr == ADDR_MODE_CTRL)
        rdata <= mode_q;
      else if (addr == ADDR_RX_STATUS)
        rdata <= {5'h00, status_q};
      else if (addr == ADDR_RX_BUFFER)
        rdata <= rx_buf_q;
      else if (addr == ADDR_CLK_SELECT)
        rdata <= clk_sel_q;
      else if (addr == ADDR_BAUD_DIV)
        rdata <= baud_div_q;
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end

  // ===========================================================
  // Base clock: prescaler tap as a one-cycle enable
  logic [15:0] presc_q;
  logic [15:0] tap_mask;
  logic        base_tick;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      presc_q <= '0;
    else if (!unit_en)
      presc_q <= '0;
    else
      presc_q <= presc_q + 16'h0001;
  end
  // Tap n ticks every 2^n system clocks; held off while disabled
  assign tap_mask  = (16'h0001 << clk_sel_q[3:0]) - 16'h0001;
  assign base_tick = unit_en && ((presc_q & tap_mask) == 16'h0000);

  // ===========================================================
  // Noise filter
  logic smp_q, filt_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      smp_q  <= 1'b1;
      filt_q <= 1'b1;
    end
    else if (base_tick)
    begin
      smp_q <= rx_pin;
      if (rx_pin == smp_q)
        filt_q <= rx_pin;
    end
  end

  // ===========================================================
  // Dividers
  logic rx_half, tx_half, rx_restart, tx_restart;
  baud_divider #(.W(DIV_W)) u_rx_div (
    .clk       (clk),
    .rst       (rst),
    .base_tick (base_tick),
    .restart   (rx_restart),
    .divisor_k (baud_div_q),
    .half_tick (rx_half)
  );
  baud_divider #(.W(DIV_W)) u_tx_div (
    .clk       (clk),
    .rst       (rst),
    .base_tick (base_tick),
    .restart   (tx_restart),
    .divisor_k (baud_div_q),
    .half_tick (tx_half)
  );

  // ===========================================================
  // Receiver
  rx_state_e  rx_st_q;
  logic [3:0] bit_q;
  logic       phase_q;
  logic [8:0] shift_q;
  logic       filt_d1_q, rx_full_q;
  logic       frame_end, par_err, frm_err, ovr_err, any_err, status_rd;
  logic [3:0] nbits;
  logic [7:0] rx_data;
  assign nbits = 4'(len8 ? 8 : 7) + ((par_mode == PAR_NONE) ? 4'h0 : 4'h1);
  assign rx_restart = (rx_st_q == RX_IDLE);
  // Data LSB first; parity bit sits just above data
  assign rx_data = len8 ? shift_q[7:0] : {1'b0, shift_q[6:0]};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_st_q   <= RX_IDLE;
      bit_q     <= '0;
      phase_q   <= 1'b0;
      shift_q   <= '0;
      filt_d1_q <= 1'b1;
    end
    else if (!rx_en)
    begin
      rx_st_q   <= RX_IDLE;
      filt_d1_q <= filt_q;
    end
    else
    begin
      filt_d1_q <= filt_q;
      case (rx_st_q)
        RX_IDLE:
          if (filt_d1_q && !filt_q)
            rx_st_q <= RX_START;
        RX_START:
          if (rx_half)
          begin
            if (!filt_q)
            begin
              rx_st_q <= RX_DATA;
              bit_q   <= '0;
              phase_q <= 1'b0;
            end
            else
              rx_st_q <= RX_IDLE;
          end
        RX_DATA:
          if (rx_half)
          begin
            phase_q <= ~phase_q;
            if (phase_q)
            begin
              shift_q[bit_q] <= filt_q;
              bit_q   <= bit_q + 4'h1;
              if (bit_q == nbits - 4'h1)
                rx_st_q <= RX_STOP;
            end
          end
        RX_STOP:
          if (rx_half)
          begin
            phase_q <= ~phase_q;
            if (phase_q)
              rx_st_q <= RX_IDLE;
          end
        default:
          rx_st_q <= RX_IDLE;
      endcase
    end
  end

  assign frame_end = rx_en && rx_st_q == RX_STOP && rx_half && phase_q;
  always_comb
  begin
    case (par_mode)
      PAR_EVEN: par_err = (^rx_data) ^ shift_q[nbits - 4'h1];
      PAR_ODD:  par_err = ~((^rx_data) ^ shift_q[nbits - 4'h1]);
      default:  par_err = 1'b0;
    endcase
  end
  assign frm_err   = !filt_q;
  assign ovr_err   = rx_full_q;
  assign any_err   = par_err | frm_err | ovr_err;
  assign status_rd = rd && addr == ADDR_RX_STATUS;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_buf_q  <= 8'h00;
      rx_full_q <= 1'b0;
    end
    else
    begin
      if (frame_end && !ovr_err)
      begin
        rx_buf_q  <= rx_data;
        rx_full_q <= 1'b1;
      end
      else if (rd && addr == ADDR_RX_BUFFER)
        rx_full_q <= 1'b0;
    end
  end

  // Set wins over the read-clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_q <= 3'h0;
    else if (frame_end)
      status_q <= (status_rd ? 3'h0 : status_q) | {par_err, frm_err, ovr_err};
    else if (status_rd)
      status_q <= 3'h0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_done_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
    end
    else
    begin
      rx_done_irq  <= frame_end && (!any_err || merge);
      rx_error_irq <= frame_end && any_err && !merge;
    end
  end

  // ===========================================================
  // Minimal transmitter for parity generation
  logic [10:0] tx_sh_q;
  logic [3:0]  tx_cnt_q;
  logic        tx_ph_q;
  assign tx_restart = (tx_cnt_q == 4'h0);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_sh_q     <= '1;
      tx_cnt_q    <= '0;
      tx_ph_q     <= 1'b0;
      tx_pin      <= 1'b1;
      tx_done_irq <= 1'b0;
    end
    else
    begin
      tx_done_irq <= 1'b0;
      if (!tx_en)
      begin
        tx_cnt_q <= '0;
        tx_pin   <= 1'b1;
      end
      else if (tx_cnt_q == 4'h0 && tx_start_q)
      begin
        if (par_mode == PAR_NONE)
          tx_sh_q <= len8 ? {2'b11, tx_data_q, 1'b0} : {3'b111, tx_data_q[6:0], 1'b0};
        else
          tx_sh_q <= len8 ? {1'b1, par_bit(tx_data_q, 1'b1, par_mode), tx_data_q, 1'b0}
                          : {2'b11, par_bit(tx_data_q, 1'b0, par_mode), tx_data_q[6:0], 1'b0};
        tx_cnt_q <= nbits + 4'h2;
        tx_ph_q  <= 1'b0;
      end
      else if (tx_cnt_q != 4'h0 && tx_half)
      begin
        tx_ph_q <= ~tx_ph_q;
        if (!tx_ph_q)
        begin
          tx_pin  <= tx_sh_q[0];
          tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        end
        else
        begin
          tx_cnt_q <= tx_cnt_q - 4'h1;
          if (tx_cnt_q == 4'h1)
            tx_done_irq <= 1'b1;
        end
      end
    end
  end

  // ===========================================================
  // Checks
  a_disabled_quiet: assert property (@(posedge clk) disable iff (rst)
    !rx_en |=> !rx_done_irq && !rx_error_irq)
    else $error("receive interrupt while disabled");
  a_error_sets_flag: assert property (@(posedge clk) disable iff (rst)
    frame_end && any_err |=> status_q != 3'h0)
    else $error("error flag not set");
  a_merge_routing: assert property (@(posedge clk) disable iff (rst)
    rx_error_irq |-> !$past(merge))
    else $error("error irq while merged");
  a_status_clear: assert property (@(posedge clk) disable iff (rst)
    status_rd && !frame_end |=> status_q == 3'h0)
    else $error("status not cleared by read");
  a_zero_parity_ok: assert property (@(posedge clk) disable iff (rst)
    frame_end && par_mode == PAR_ZERO |=> !status_q[STAT_PARITY] || $past(status_q[STAT_PARITY]))
    else $error("parity error in zero mode");
  a_base_low_off: assert property (@(posedge clk) disable iff (rst)
    !unit_en |-> !base_tick)
    else $error("base clock runs while disabled");
  a_filter_two: assert property (@(posedge clk) disable iff (rst)
    $changed(filt_q) |-> $past(smp_q) == filt_q)
    else $error("filter changed without agreement");
  a_overrun_keeps: assert property (@(posedge clk) disable iff (rst)
    frame_end && ovr_err |=> $stable(rx_buf_q))
    else $error("buffer overwritten on overrun");
endmodule // serial_rx_unit
`default_nettype wire

/* File: rtl/serial_pkg.sv */
// Constants shared by the async serial channel receive and baud logic
package serial_pkg;
  // Register offsets (byte addresses on the plain port)
  localparam logic [3:0] ADDR_MODE_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_RX_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_RX_BUFFER  = 4'h2;
  localparam logic [3:0] ADDR_CLK_SELECT = 4'h3;
  localparam logic [3:0] ADDR_BAUD_DIV   = 4'h4;
  localparam logic [3:0] ADDR_TX_DATA    = 4'h5;
  // serial_mode_ctrl fields
  localparam int MODE_UNIT_EN  = 7;
  localparam int MODE_TX_EN    = 6;
  localparam int MODE_RX_EN    = 5;
  localparam int MODE_PAR_HI   = 4;
  localparam int MODE_PAR_LO   = 3;
  localparam int MODE_LEN8     = 1;
  localparam int MODE_IRQ_MERGE = 0;
  localparam logic [7:0] MODE_RESET = 8'h02;
  // rx_status fields
  localparam int STAT_PARITY  = 2;
  localparam int STAT_FRAMING = 1;
  localparam int STAT_OVERRUN = 0;
  // Other reset values and the divisor minimum
  localparam logic [7:0] CLK_SELECT_RESET = 8'h00;
  localparam logic [7:0] BAUD_DIV_RESET   = 8'hff;
  localparam logic [7:0] BAUD_DIV_MIN     = 8'h08;
  // Parity modes
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD  = 2'b10,
    PAR_EVEN = 2'b11
  } parity_e;
endpackage

/* File: rtl/baud_divider.sv */
// Base-clock-enabled divider that marks each half bit time
`timescale 1ns/1ps
`default_nettype none
module baud_divider
  import serial_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         base_tick,
  input  wire logic         restart,
  input  wire logic [W-1:0] divisor_k,
  output logic              half_tick
);
  logic [W-1:0] cnt_q;

  // Counts divisor_k base clocks per half bit; restart realigns phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q     <= '0;
      half_tick <= 1'b0;
    end
    else if (restart)
    begin
      cnt_q     <= '0;
      half_tick <= 1'b0;
    end
    else if (base_tick)
    begin
      if (cnt_q >= divisor_k - W'(1))
      begin
        cnt_q     <= '0;
        half_tick <= 1'b1;
      end
      else
      begin
        cnt_q     <= cnt_q + W'(1);
        half_tick <= 1'b0;
      end
    end
    else
    begin
      half_tick <= 1'b0;
    end
  end
endmodule // baud_divider
`default_nettype wire

/* File: tb/serial_peer.sv */
// Remote line partner: sends frames onto the receive line, listens on tx
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input  wire logic        clk,
  input  wire logic        send,
  input  wire logic [11:0] frame_bits,
  input  wire logic [3:0]  frame_len,
  input  wire logic [8:0]  bit_cyc,
  input  wire logic        glitch,
  input  wire logic        tx_pin,
  output logic             line,
  output logic             busy = 1'b0,
  output logic [11:0]      heard = '0
);
  // ==========
  // Sender, LSB first, idle high
  logic [11:0] sh_q  = '1;
  int          scnt  = 0;
  int          sbits = 0;
  int          rcnt  = 0;
  int          rbits = 0;
  logic        tx_d1 = 1'b1;
  always_ff @(posedge clk)
  begin
    if (send)
    begin
      sh_q  <= frame_bits;
      sbits <= frame_len;
      scnt  <= bit_cyc;
      busy  <= 1'b1;
    end
    else if (busy && scnt == 1)
    begin
      sh_q  <= {1'b1, sh_q[11:1]};
      sbits <= sbits - 1;
      scnt  <= bit_cyc;
      busy  <= (sbits > 1);
    end
    else if (busy)
      scnt <= scnt - 1;
  end
  assign line = sh_q[0] ^ glitch;
  // ==========
  // Listener, samples mid-bit
  always_ff @(posedge clk)
  begin
    tx_d1 <= tx_pin;
    if (rbits == 0 && tx_d1 && !tx_pin)
    begin
      rbits <= frame_len;
      rcnt  <= bit_cyc / 2;
    end
    else if (rbits != 0 && rcnt == 1)
    begin
      heard <= {tx_pin, heard[11:1]};
      rbits <= rbits - 1;
      rcnt  <= bit_cyc;
    end
    else if (rbits != 0)
      rcnt <= rcnt - 1;
  end
endmodule // serial_peer
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the serial receive unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import serial_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = '0;
  logic [7:0]  wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        send = 1'b0;
  logic        glitch = 1'b0;
  logic [11:0] frame_bits = '1;
  logic [3:0]  frame_len = '0;
  logic [8:0]  bit_cyc = 9'd128;
  logic [7:0]  rdata;
  logic [11:0] heard;
  logic [11:0] b;
  logic        tx_pin, rx_line, busy, rx_done_irq, rx_error_irq, tx_done_irq;
  logic [1:0]  par = PAR_EVEN;
  bit          len8 = 1'b1;
  bit          merge = 1'b0;
  bit          unread = 1'b0;
  logic [7:0]  exp_buf = '0;
  logic [7:0]  exp_stat = '0;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          seed = 32'h76faca33;
  int          done_n = 0;
  int          err_n = 0;
  int          txd_n = 0;
  int          d0, e0, i, j;
  int          taps[3] = '{4, 3, 3};
  int          ks[3] = '{8, 9, 8};

  serial_rx_unit serial_rx_unit_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_pin(rx_line), .tx_pin(tx_pin),
    .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq));
  serial_peer serial_peer_inst (.clk(clk), .send(send), .frame_bits(frame_bits),
    .frame_len(frame_len), .bit_cyc(bit_cyc), .glitch(glitch), .tx_pin(tx_pin),
    .line(rx_line), .busy(busy), .heard(heard));

  initial
  begin
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    done_n += (rx_done_irq === 1'b1);
    err_n  += (rx_error_irq === 1'b1);
    txd_n  += (tx_done_irq === 1'b1);
  end

  // ==========
  // Checking and bus tasks
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check({4'h0, rdata}, {4'h0, e});
  endtask

  task automatic set_mode(input bit u, input bit r);
    wr_reg(ADDR_MODE_CTRL, {u, r, r, par, 1'b0, len8, merge});
  endtask

  task automatic set_rate(input int tap, input int k);
    set_mode(1'b0, 1'b0);
    wr_reg(ADDR_CLK_SELECT, 8'(tap));
    wr_reg(ADDR_BAUD_DIV, 8'(k));
    bit_cyc = 9'((2 * k) << tap);
    set_mode(1'b1, 1'b1);
  endtask

  // ==========
  // Frame model and line tasks
  function automatic logic [11:0] build(input logic [7:0] d, input bit fl, input bit st,
                                        output int n);
    logic [11:0] f;
    logic        p;
    p = len8 ? ^d : ^d[6:0];
    f = '1;
    f[0] = 1'b0;
    n = len8 ? 9 : 8;
    for (int k = 1; k < n; k++)
      f[k] = d[k-1];
    if (par != PAR_NONE)
    begin
      f[n] = fl ^ (par == PAR_EVEN ? p : par == PAR_ODD ? ~p : 1'b0);
      n++;
    end
    f[n] = st;
    n++;
    return f;
  endfunction

  task automatic launch(input logic [11:0] f, input int n);
    @(posedge clk);
    frame_bits <= f;
    frame_len  <= 4'(n);
    send       <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    #1;
  endtask

  task automatic settle();
    int k;
    for (k = 0; k < 4000 && busy; k++)
      @(posedge clk);
    if (busy)
    begin
      error_cnt++;
      tally_and_finish();
    end
    repeat (100) @(posedge clk);
  endtask

  task automatic read_back();
    rd_chk(ADDR_RX_BUFFER, exp_buf);
    unread = 1'b0;
    rd_chk(ADDR_RX_STATUS, exp_stat);
    exp_stat = '0;
    rd_chk(ADDR_RX_STATUS, 8'h00);
  endtask

  task automatic rx_frame(input logic [7:0] d, input bit fl, input bit st, input bit rb);
    logic [11:0] f;
    logic [2:0]  err;
    int          n, dd, ee;
    f = build(d, fl, st, n);
    dd = done_n;
    ee = err_n;
    err = {fl & par[1], !st, unread};
    launch(f, n);
    settle();
    exp_stat |= {5'h0, err};
    if (!unread)
    begin
      exp_buf = d & {len8, 7'h7f};
      unread = 1'b1;
    end
    check(12'(err_n - ee), {11'h0, !merge && err != 0});
    check(12'(done_n - dd), {11'h0, merge || err == 0});
    if (rb)
      read_back();
  endtask

  task automatic tx_frame(input logic [7:0] d);
    logic [11:0] f;
    int          n, t0, k;
    f = build(d, 1'b0, 1'b1, n);
    t0 = txd_n;
    frame_len <= 4'(n);
    wr_reg(ADDR_TX_DATA, d);
    for (k = 0; k < 4000 && txd_n == t0; k++)
      @(posedge clk);
    if (txd_n == t0)
    begin
      error_cnt++;
      tally_and_finish();
    end
    repeat (300) @(posedge clk);
    check(heard >> (12 - n), f & ((12'h001 << n) - 12'h001));
    check(12'(txd_n - t0), 12'h1);
  endtask

  // ==========
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_MODE_CTRL, MODE_RESET);
    rd_chk(ADDR_CLK_SELECT, CLK_SELECT_RESET);
    rd_chk(ADDR_BAUD_DIV, BAUD_DIV_RESET);
    rd_chk(ADDR_RX_STATUS, 8'h00);
    rd_chk(4'hf, 8'h00);
    wr_reg(ADDR_BAUD_DIV, 8'h03);
    rd_chk(ADDR_BAUD_DIV, BAUD_DIV_MIN);
    $display("test registers done");
    for (i = 0; i < 3; i++)
    begin
      set_rate(taps[i], ks[i]);
      rx_frame(8'($random(seed)), 1'b0, 1'b1, 1'b1);
    end
    $display("test rates done");
    for (i = 0; i < 4; i++)
    begin
      par = 2'(i);
      set_mode(1'b1, 1'b1);
      for (j = 0; j < 2; j++)
        rx_frame(8'($random(seed)), j[0], 1'b1, 1'b1);
      tx_frame(8'($random(seed)));
    end
    $display("test parity done");
    par = PAR_EVEN;
    len8 = 1'b0;
    set_mode(1'b1, 1'b1);
    rx_frame(8'hb1, 1'b1, 1'b1, 1'b1);
    len8 = 1'b1;
    merge = 1'b1;
    set_mode(1'b1, 1'b1);
    rx_frame(8'($random(seed)), 1'b1, 1'b1, 1'b1);
    merge = 1'b0;
    set_mode(1'b1, 1'b1);
    rx_frame(8'($random(seed)), 1'b0, 1'b0, 1'b1);
    rx_frame(8'h3c, 1'b0, 1'b0, 1'b0);
    rx_frame(8'hc3, 1'b0, 1'b1, 1'b0);
    read_back();
    $display("test errors done");
    d0 = done_n;
    e0 = err_n;
    b = build(8'h5a, 1'b1, 1'b0, j);
    launch(b, j);
    repeat (400) @(posedge clk);
    set_mode(1'b1, 1'b0);
    settle();
    set_mode(1'b0, 1'b1);
    launch(b, j);
    settle();
    check(12'(done_n - d0), 12'h0);
    check(12'(err_n - e0), 12'h0);
    set_mode(1'b1, 1'b1);
    read_back();
    @(posedge clk);
    glitch <= 1'b1;
    repeat (6) @(posedge clk);
    glitch <= 1'b0;
    repeat (2000) @(posedge clk);
    check(12'(done_n - d0), 12'h0);
    rd_chk(ADDR_RX_STATUS, 8'h00);
    $display("test abort and noise done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
